/* coc_params.svh */
// register offsets, field positions, reset values and counts of the output clock control
`ifndef COC_PARAMS_SVH
`define COC_PARAMS_SVH
`define COC_NUM_OUT 18
`define COC_NUM_LOOP 3
`define COC_A_CTRL 8'h00
`define COC_A_STEP_WORD 8'h01
`define COC_A_STEP_CMD 8'h02
`define COC_A_STEP_PIN 8'h03
`define COC_A_EXT_FB 8'h04
`define COC_A_FRAC_SRC 8'h05
`define COC_A_FRAC_INC 8'h06
`define COC_A_LOOP_FREQ 8'h08
`define COC_A_STATUS 8'h0f
`define COC_A_OUT_CFG 8'h20
`define COC_A_OUT_DIV 8'h40
`define COC_A_OUT_EN 8'h60
`define COC_NVM_LAST 8'h5f
`define COC_CTRL_RESYNC 0
`define COC_CTRL_FINE 1
`define COC_CMD_UP 0
`define COC_CMD_DN 1
`define COC_CMD_MASK 2
`define COC_FSRC_AUX 0
`define COC_FSRC_CASC 1
`define COC_CFG_ROUTE 0
`define COC_CFG_PIN_MODE 2
`define COC_CFG_GRP 3
`define COC_CFG_SW_EN 5
`define COC_CFG_IDLE 6
`define COC_CFG_SE 9
`define COC_CFG_INV_P 10
`define COC_CFG_INV_N 11
`define COC_CFG_EN_P 12
`define COC_CFG_EN_N 13
`define COC_CFG_SLOW 14
`define COC_CFG_SRL 15
`define COC_DIV_RATIO 0
`define COC_DIV_SKEW 16
`define COC_CFG_RST 32'h0000_0020
`define COC_DIV_RST 32'h0000_0004
`define COC_FREQ_RST 32'h1000_0000
`define COC_STEP_UP_PIN_RST 32'h4000_0000
`define COC_STEP_RST 32'h0000_0001
`define COC_MIN_RATIO 16'h0002
`define COC_IDLE_LOW 3'h0
`define COC_IDLE_HIGH 3'h1
`define COC_IDLE_HIZ 3'h2
`define COC_IDLE_PU 3'h3
`define COC_IDLE_PD 3'h4
`endif

/* coc_pkg.sv */
// types and pin decode function of the output clock control
`include "coc_params.svh"
package coc_pkg;
  typedef enum logic [1:0] {
    COC_LOAD = 2'b00,
    COC_DRAIN = 2'b01,
    COC_RUN = 2'b11
  } coc_state_e;

  typedef struct packed {
    logic d;
    logic oe;
    logic pu;
    logic pd;
  } coc_pin_s;

  function automatic coc_pin_s coc_pin_drive(input logic lvl, input logic on,
      input logic [2:0] idle, input logic weak_ok, input logic flip);
    coc_pin_s p;
    p = '0;
    if (on) begin
      p.d = lvl;
      p.oe = 1'b1;
    end else begin
      case (idle)
        `COC_IDLE_LOW: begin
          p.d = flip;
          p.oe = 1'b1;
        end
        `COC_IDLE_HIGH: begin
          p.d = ~flip;
          p.oe = 1'b1;
        end
        `COC_IDLE_PU: p.pu = weak_ok;
        `COC_IDLE_PD: p.pd = weak_ok;
        default: p.oe = 1'b0;
      endcase
    end
    return p;
  endfunction : coc_pin_drive
endpackage : coc_pkg

/* coc_clock_output_control.sv */
// output path control: crosspoint, dividers, skew, enables, idle states, frequency stepping
`include "coc_params.svh"
// Summary of operation
// - two enable group pins ORed for pin-controlled outputs
// - pin-controlled outputs ignore software enable bit
// - software enables each output individually
// - disabled driver idles low, high or hi-z
// - slow single-ended outputs add weak pull idle
// - single-ended pins: own polarity and enable
// - crosspoint connects any output to any loop
// - integer dividers have programmable digital delay
// - skew steps one period or quarter period
// - routing and delays loaded from storage at startup
// - integer dividers integer-only, open-loop from oscillator
// - feedback and fractional dividers fractional, post integer
// - fractional dividers cascadable from a common source
// - secondary loops bypass the integer dividers
// - second fractional divider selects primary or aux
// - tunable oscillators step by programmed word
// - stepping accepted in any loop lock state
// - stepping by command or by step pins
// - step up adds word, step down subtracts
// - each loop assignable to the step pins
// - each loop has external feedback delay mode
module coc_clock_output_control
  import coc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic [7:0] nvm_addr,
  input wire logic [31:0] nvm_data,
  input wire logic enable_group_zero,
  input wire logic enable_group_one,
  input wire logic step_up_pin,
  input wire logic step_down_pin,
  output logic [17:0] out_p,
  output logic [17:0] out_n,
  output logic [17:0] oe_p,
  output logic [17:0] oe_n,
  output logic [17:0] weak_up,
  output logic [17:0] weak_dn,
  output logic [35:0] fine_phase,
  output logic [1:0] slow_edge_cmos,
  output logic [2:0] external_feedback_delay_mode,
  output logic load_busy
);
  localparam int NO = `COC_NUM_OUT;
  localparam int NL = `COC_NUM_LOOP;

  // reset release through two flops
  logic rst_meta_reg;
  logic rst_n;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n <= rst_meta_reg;
    end
  end

  // pin synchronisers: groups 1:0, step up 2, step down 3
  logic [3:0] pin_meta_reg;
  logic [3:0] pin_sync_reg;
  logic [1:0] step_prev_reg;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_reg <= 4'h3;
      pin_sync_reg <= 4'h3;
      step_prev_reg <= 2'h0;
    end else begin
      pin_meta_reg <= {step_down_pin, step_up_pin, enable_group_one, enable_group_zero};
      pin_sync_reg <= pin_meta_reg;
      step_prev_reg <= pin_sync_reg[3:2];
    end
  end
  logic [1:0] grp_en;
  logic pin_up;
  logic pin_dn;
  assign grp_en = pin_sync_reg[1:0];
  assign pin_up = pin_sync_reg[2] & ~step_prev_reg[0];
  assign pin_dn = pin_sync_reg[3] & ~step_prev_reg[1];

  // startup load of the configuration image
  coc_state_e state_reg;
  coc_state_e state_next;
  logic [7:0] ld_addr_reg;
  logic [7:0] ld_addr_next;
  logic ld_wr_reg;
  logic [7:0] ld_wa_reg;
  logic resync_start_reg;
  always_comb begin
    state_next = state_reg;
    ld_addr_next = ld_addr_reg;
    unique case (state_reg)
      COC_LOAD: begin
        ld_addr_next = ld_addr_reg + 8'h01;
        if (ld_addr_reg == `COC_NVM_LAST) begin
          state_next = COC_DRAIN;
        end
      end
      COC_DRAIN: state_next = COC_RUN;
      COC_RUN: state_next = COC_RUN;
      default: state_next = COC_LOAD;
    endcase
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= COC_LOAD;
      ld_addr_reg <= 8'h00;
      ld_wr_reg <= 1'b0;
      ld_wa_reg <= 8'h00;
      resync_start_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      ld_addr_reg <= ld_addr_next;
      ld_wr_reg <= (state_reg == COC_LOAD);
      ld_wa_reg <= ld_addr_reg;
      resync_start_reg <= (state_reg == COC_DRAIN);
    end
  end
  assign nvm_addr = ld_addr_reg;
  assign load_busy = (state_reg != COC_RUN);

  // software writes are ignored while the image loads
  logic run;
  logic wr_en;
  logic [7:0] wa;
  logic [31:0] wd;
  assign run = (state_reg == COC_RUN);
  assign wr_en = run ? reg_wr : ld_wr_reg;
  assign wa = run ? reg_addr : ld_wa_reg;
  assign wd = run ? reg_wdata : nvm_data;

  logic resync;
  logic cmd_wr;
  assign resync = (run & reg_wr & (reg_addr == `COC_A_CTRL) & reg_wdata[`COC_CTRL_RESYNC])
    | resync_start_reg;
  assign cmd_wr = run & reg_wr & (reg_addr == `COC_A_STEP_CMD);

  // register file
  logic fine_reg, fine_next;
  logic [31:0] step_word_reg, step_word_next;
  logic [2:0] step_pin_reg, step_pin_next;
  logic [2:0] ext_fb_reg, ext_fb_next;
  logic [1:0] frac_src_reg, frac_src_next;
  logic [31:0] frac_inc_reg [2];
  logic [31:0] frac_inc_next [2];
  logic [31:0] freq_reg [NL];
  logic [31:0] freq_next [NL];
  logic [31:0] cfg_reg [NO];
  logic [31:0] cfg_next [NO];
  logic [31:0] div_reg [NO];
  logic [31:0] div_next [NO];
  logic up_cmd, dn_cmd;
  logic [2:0] cmd_mask;
  assign up_cmd = cmd_wr & reg_wdata[`COC_CMD_UP];
  assign dn_cmd = cmd_wr & reg_wdata[`COC_CMD_DN];
  assign cmd_mask = reg_wdata[`COC_CMD_MASK +: 3];

  always_comb begin
    logic up;
    logic dn;
    up = 1'b0;
    dn = 1'b0;
    fine_next = fine_reg;
    step_word_next = step_word_reg;
    step_pin_next = step_pin_reg;
    ext_fb_next = ext_fb_reg;
    frac_src_next = frac_src_reg;
    if (wr_en && wa == `COC_A_CTRL) fine_next = wd[`COC_CTRL_FINE];
    if (wr_en && wa == `COC_A_STEP_WORD) step_word_next = wd;
    if (wr_en && wa == `COC_A_STEP_PIN) step_pin_next = wd[2:0];
    if (wr_en && wa == `COC_A_EXT_FB) ext_fb_next = wd[2:0];
    if (wr_en && wa == `COC_A_FRAC_SRC) frac_src_next = wd[1:0];
    for (int f = 0; f < 2; f++) begin
      frac_inc_next[f] = frac_inc_reg[f];
      if (wr_en && wa == `COC_A_FRAC_INC + 8'(f)) frac_inc_next[f] = wd;
    end
    // stepping ignores lock state
    for (int l = 0; l < NL; l++) begin
      freq_next[l] = freq_reg[l];
      up = (pin_up & step_pin_reg[l]) | (up_cmd & cmd_mask[l]);
      dn = (pin_dn & step_pin_reg[l]) | (dn_cmd & cmd_mask[l]);
      if (wr_en && wa == `COC_A_LOOP_FREQ + 8'(l)) begin
        freq_next[l] = wd;
      end else if (up && !dn) begin
        freq_next[l] = freq_reg[l] + step_word_reg;
      end else if (dn && !up) begin
        freq_next[l] = freq_reg[l] - step_word_reg;
      end
    end
    for (int k = 0; k < NO; k++) begin
      cfg_next[k] = cfg_reg[k];
      div_next[k] = div_reg[k];
      if (wr_en && wa == `COC_A_OUT_CFG + 8'(k)) cfg_next[k] = wd;
      if (wr_en && wa == `COC_A_OUT_DIV + 8'(k)) div_next[k] = wd;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      fine_reg <= 1'b0;
      step_word_reg <= `COC_STEP_RST;
      step_pin_reg <= 3'h0;
      ext_fb_reg <= 3'h0;
      frac_src_reg <= 2'h0;
      for (int f = 0; f < 2; f++) frac_inc_reg[f] <= `COC_STEP_UP_PIN_RST;
      for (int l = 0; l < NL; l++) freq_reg[l] <= `COC_FREQ_RST;
      for (int k = 0; k < NO; k++) begin
        cfg_reg[k] <= `COC_CFG_RST;
        div_reg[k] <= `COC_DIV_RST;
      end
    end else begin
      fine_reg <= fine_next;
      step_word_reg <= step_word_next;
      step_pin_reg <= step_pin_next;
      ext_fb_reg <= ext_fb_next;
      frac_src_reg <= frac_src_next;
      frac_inc_reg <= frac_inc_next;
      freq_reg <= freq_next;
      cfg_reg <= cfg_next;
      div_reg <= div_next;
    end
  end
  assign external_feedback_delay_mode = ext_fb_reg;

  // loop oscillators and fractional dividers
  logic [31:0] loop_acc_reg [NL];
  logic [31:0] frac_acc_reg [2];
  logic [1:0] fsrc_prev_reg;
  logic [NL-1:0] loop_lvl;
  logic [1:0] frac_lvl;
  logic [1:0] fsrc;
  always_comb begin
    for (int l = 0; l < NL; l++) loop_lvl[l] = loop_acc_reg[l][31];
    frac_lvl = {frac_acc_reg[1][31], frac_acc_reg[0][31]};
    fsrc[0] = loop_lvl[0];
    if (frac_src_reg[`COC_FSRC_CASC]) begin
      fsrc[1] = frac_lvl[0];
    end else begin
      fsrc[1] = frac_src_reg[`COC_FSRC_AUX] ? loop_lvl[1] : loop_lvl[0];
    end
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int l = 0; l < NL; l++) loop_acc_reg[l] <= 32'h0000_0000;
      for (int f = 0; f < 2; f++) frac_acc_reg[f] <= 32'h0000_0000;
      fsrc_prev_reg <= 2'h0;
    end else begin
      for (int l = 0; l < NL; l++) loop_acc_reg[l] <= loop_acc_reg[l] + freq_reg[l];
      for (int f = 0; f < 2; f++) begin
        if (fsrc[f] && !fsrc_prev_reg[f]) begin
          frac_acc_reg[f] <= frac_acc_reg[f] + frac_inc_reg[f];
        end
      end
      fsrc_prev_reg <= fsrc;
    end
  end

  // per-output divider, skew, enable and pin drive
  logic [15:0] cnt_reg [NO];
  logic [15:0] cnt_next [NO];
  logic [7:0] hold_reg [NO];
  logic [7:0] hold_next [NO];
  logic [NO-1:0] en_reg, en_next;
  logic [NO-1:0] src_prev_reg;
  logic [NO-1:0] src_lvl;
  logic [NO-1:0] p_d_next, n_d_next, p_oe_next, n_oe_next, pu_next, pd_next;

  for (genvar i = 0; i < NO; i++) begin : g_out
    logic [1:0] route;
    logic [15:0] ratio;
    logic [7:0] coarse;
    logic want;
    logic tick;
    logic lvl;
    logic se;
    logic weak_ok;
    coc_pin_s pp;
    coc_pin_s np;
    assign route = cfg_reg[i][`COC_CFG_ROUTE +: 2];
    assign se = cfg_reg[i][`COC_CFG_SE];
    // ratio below two is clamped, integer only
    assign ratio = (div_reg[i][`COC_DIV_RATIO +: 16] < `COC_MIN_RATIO) ? `COC_MIN_RATIO :
      div_reg[i][`COC_DIV_RATIO +: 16];
    // fine mode: low two bits go to the analog quarter-step delay
    assign coarse = fine_reg ? {2'b00, div_reg[i][`COC_DIV_SKEW + 2 +: 6]} :
      div_reg[i][`COC_DIV_SKEW +: 8];
    assign fine_phase[2*i +: 2] = fine_reg ? div_reg[i][`COC_DIV_SKEW +: 2] : 2'b00;
    assign want = cfg_reg[i][`COC_CFG_PIN_MODE] ?
      |(cfg_reg[i][`COC_CFG_GRP +: 2] & grp_en) :
      cfg_reg[i][`COC_CFG_SW_EN];
    // crosspoint: integer path from the oscillator only, aux loops via fractional/post
    always_comb begin
      unique case (route)
        2'd0: src_lvl[i] = 1'b1;
        2'd1: src_lvl[i] = frac_lvl[0];
        2'd2: src_lvl[i] = frac_lvl[1];
        2'd3: src_lvl[i] = loop_lvl[2];
      endcase
    end
    assign tick = (route == 2'd0) | (src_lvl[i] & ~src_prev_reg[i]);
    assign lvl = (hold_reg[i] == 8'h00) && (cnt_reg[i] < (ratio >> 1));
    always_comb begin
      cnt_next[i] = cnt_reg[i];
      hold_next[i] = hold_reg[i];
      en_next[i] = en_reg[i];
      if (resync) begin
        cnt_next[i] = 16'h0000;
        hold_next[i] = (route == 2'd0) ? coarse : 8'h00;
      end else if (hold_reg[i] != 8'h00) begin
        hold_next[i] = hold_reg[i] - 8'h01;
      end else if (tick) begin
        if (cnt_reg[i] == ratio - 16'h0001) begin
          cnt_next[i] = 16'h0000;
          en_next[i] = want & run;
        end else begin
          cnt_next[i] = cnt_reg[i] + 16'h0001;
        end
      end
    end
    assign weak_ok = se & cfg_reg[i][`COC_CFG_SLOW];
    always_comb begin
      if (se) begin
        pp = coc_pin_drive(lvl ^ cfg_reg[i][`COC_CFG_INV_P],
          en_reg[i] & cfg_reg[i][`COC_CFG_EN_P], cfg_reg[i][`COC_CFG_IDLE +: 3],
          weak_ok, 1'b0);
        np = coc_pin_drive(lvl ^ cfg_reg[i][`COC_CFG_INV_N],
          en_reg[i] & cfg_reg[i][`COC_CFG_EN_N], cfg_reg[i][`COC_CFG_IDLE +: 3],
          weak_ok, 1'b0);
      end else begin
        pp = coc_pin_drive(lvl, en_reg[i], cfg_reg[i][`COC_CFG_IDLE +: 3], 1'b0, 1'b0);
        np = coc_pin_drive(~lvl, en_reg[i], cfg_reg[i][`COC_CFG_IDLE +: 3], 1'b0, 1'b1);
      end
      p_d_next[i] = pp.d;
      n_d_next[i] = np.d;
      p_oe_next[i] = pp.oe;
      n_oe_next[i] = np.oe;
      pu_next[i] = pp.pu | np.pu;
      pd_next[i] = pp.pd | np.pd;
    end
  end

  assign slow_edge_cmos = {cfg_reg[NO-1][`COC_CFG_SRL], cfg_reg[NO-2][`COC_CFG_SRL]};

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int k = 0; k < NO; k++) begin
        cnt_reg[k] <= 16'h0000;
        hold_reg[k] <= 8'h00;
      end
      en_reg <= '0;
      src_prev_reg <= '0;
      out_p <= '0;
      out_n <= '0;
      oe_p <= '0;
      oe_n <= '0;
      weak_up <= '0;
      weak_dn <= '0;
    end else begin
      cnt_reg <= cnt_next;
      hold_reg <= hold_next;
      en_reg <= en_next;
      src_prev_reg <= src_lvl;
      out_p <= p_d_next;
      out_n <= n_d_next;
      oe_p <= p_oe_next;
      oe_n <= n_oe_next;
      weak_up <= pu_next;
      weak_dn <= pd_next;
    end
  end

  // read port, data one cycle after the strobe
  logic [31:0] rdata_next;
  always_comb begin
    logic [7:0] ci;
    logic [7:0] di;
    ci = reg_addr - `COC_A_OUT_CFG;
    di = reg_addr - `COC_A_OUT_DIV;
    rdata_next = 32'h0000_0000;
    if (reg_rd) begin
      if (ci < 8'(NO)) begin
        rdata_next = cfg_reg[ci[4:0]];
      end else if (di < 8'(NO)) begin
        rdata_next = div_reg[di[4:0]];
      end else begin
        case (reg_addr)
          `COC_A_CTRL: rdata_next = {30'h0, fine_reg, 1'b0};
          `COC_A_STEP_WORD: rdata_next = step_word_reg;
          `COC_A_STEP_PIN: rdata_next = {29'h0, step_pin_reg};
          `COC_A_EXT_FB: rdata_next = {29'h0, ext_fb_reg};
          `COC_A_FRAC_SRC: rdata_next = {30'h0, frac_src_reg};
          `COC_A_FRAC_INC: rdata_next = frac_inc_reg[0];
          `COC_A_FRAC_INC + 8'h01: rdata_next = frac_inc_reg[1];
          `COC_A_LOOP_FREQ: rdata_next = freq_reg[0];
          `COC_A_LOOP_FREQ + 8'h01: rdata_next = freq_reg[1];
          `COC_A_LOOP_FREQ + 8'h02: rdata_next = freq_reg[2];
          `COC_A_STATUS: rdata_next = {27'h0, pin_sync_reg, load_busy};
          `COC_A_OUT_EN: rdata_next = {14'h0, en_reg};
          default: rdata_next = 32'h0000_0000;
        endcase
      end
    end
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= rdata_next;
    end
  end
endmodule : coc_clock_output_control

/* coc_nvm_model.sv */
// config store model: synchronous word image read by the startup load
`include "coc_params.svh"
module coc_nvm_model (
  input wire logic clk_sys,
  input wire logic [7:0] nvm_addr,
  output logic [31:0] nvm_data
);
  timeunit 1ns;
  timeprecision 1ps;

  // step word and divider 1 differ from the register defaults to prove the load
  function automatic logic [31:0] image(input logic [7:0] a);
    if (a == `COC_A_STEP_WORD) return 32'h0000_0010;
    if (a == 8'h06 || a == 8'h07) return `COC_STEP_UP_PIN_RST;
    if (a >= 8'h08 && a <= 8'h0a) return `COC_FREQ_RST;
    if (a >= 8'h20 && a <= 8'h31) return `COC_CFG_RST;
    if (a == 8'h41) return 32'h0003_0006;
    if (a >= 8'h40 && a <= 8'h51) return `COC_DIV_RST;
    return 32'h0000_0000;
  endfunction : image

  // answer one cycle after the address, as a synchronous memory does
  always_ff @(posedge clk_sys) begin
    nvm_data <= image(nvm_addr);
  end
endmodule : coc_nvm_model

/* coc_clock_output_control_assertions.sv */
// concurrent checks on the ports of the output clock control
module coc_clock_output_control_assertions (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [7:0] nvm_addr,
  input wire logic [17:0] out_p,
  input wire logic [17:0] out_n,
  input wire logic [17:0] oe_p,
  input wire logic [17:0] oe_n,
  input wire logic [17:0] weak_up,
  input wire logic [17:0] weak_dn,
  input wire logic load_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  // driver 0 keeps its loaded ratio of 4: two ticks high, at least two low
  sequence s_high_run;
    out_p[0] [*2] ##1 !out_p[0];
  endsequence
  sequence s_low_run;
    !out_p[0] [*2];
  endsequence

  AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
    else $error("read data not zero outside a read answer");
  AST_NVM_WALK: assert property ((nvm_addr != 8'h00 && nvm_addr < 8'h60)
    |=> nvm_addr == $past(nvm_addr) + 8'h01)
    else $error("config store address did not advance by one");
  AST_LOAD_END: assert property ($fell(load_busy) |-> nvm_addr == 8'h60)
    else $error("load finished before the whole image was read");
  AST_LOAD_ONCE: assert property (!load_busy |=> !load_busy)
    else $error("load restarted without reset");
  AST_WEAK_EXCL: assert property ((weak_up & weak_dn) == 18'h00000)
    else $error("weak pull up and down at once");
  AST_WEAK_HIZ: assert property (((weak_up | weak_dn) & oe_p & oe_n) == 18'h00000)
    else $error("weak pull on a driven pin");
  AST_FULL_HIGH: assert property ($rose(out_p[0]) |-> s_high_run)
    else $error("high phase of driver 0 not two ticks");
  AST_FULL_LOW: assert property ($fell(out_p[0]) |-> s_low_run)
    else $error("low phase of driver 0 shortened");
  AST_DIFF_PAIR: assert property (oe_p[0] |-> out_n[0] == ~out_p[0])
    else $error("differential pair of driver 0 not complementary");
endmodule : coc_clock_output_control_assertions

/* tb_clock_output_control.sv */
// testbench of the output clock control
`include "coc_params.svh"
module tb_clock_output_control;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic enable_group_zero = 1'b0;
  logic enable_group_one = 1'b0;
  logic step_up_pin = 1'b0;
  logic step_down_pin = 1'b0;
  logic [31:0] reg_rdata;
  logic [7:0] nvm_addr;
  logic [31:0] nvm_data;
  logic [17:0] out_p, out_n, oe_p, oe_n, weak_up, weak_dn;
  logic [35:0] fine_phase;
  logic [1:0] slow_edge_cmos;
  logic [2:0] external_feedback_delay_mode;
  logic load_busy;
  int n_mismatch = 0;
  int total_checks = 0;
  // disabled driver 3 setups and {oe_p, out_p, out_n, weak_up, weak_dn}
  logic [31:0] cfg_t [8] = '{32'h7200, 32'h7240, 32'h7280, 32'h72c0, 32'h7300,
                             32'h32c0, 32'h7600, 32'h7a00};
  logic [4:0] exp_t [8] = '{5'h10, 5'h1c, 5'h00, 5'h02, 5'h01, 5'h00, 5'h10, 5'h10};

  coc_clock_output_control DUT (.clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .nvm_addr(nvm_addr), .nvm_data(nvm_data), .enable_group_zero(enable_group_zero),
    .enable_group_one(enable_group_one), .step_up_pin(step_up_pin),
    .step_down_pin(step_down_pin), .out_p(out_p), .out_n(out_n), .oe_p(oe_p), .oe_n(oe_n),
    .weak_up(weak_up), .weak_dn(weak_dn), .fine_phase(fine_phase),
    .slow_edge_cmos(slow_edge_cmos),
    .external_feedback_delay_mode(external_feedback_delay_mode), .load_busy(load_busy));

  coc_nvm_model u_nvm (.clk_sys(clk_sys), .nvm_addr(nvm_addr), .nvm_data(nvm_data));

  initial begin
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    chk(reg_rdata, exp);
  endtask : rchk

  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : idle

  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finish_test

  initial begin
    int k;
    logic [31:0] base;
    base = `COC_FREQ_RST;
    repeat (6) @(posedge clk_sys);
    reset_n <= 1'b1;
    for (k = 0; k < 300 && load_busy !== 1'b0; k++) @(negedge clk_sys);
    if (k == 300) begin
      n_mismatch++;
      finish_test();
    end
    rchk(`COC_A_STEP_WORD, 32'h0000_0010);
    rchk(8'h41, 32'h0003_0006);
    rchk(`COC_A_OUT_CFG, `COC_CFG_RST);
    wr(8'h7f, 32'h1234_5678);
    rchk(8'h7f, 32'h0000_0000);
    $display("test load done");
    // commands: loop 0 up; loops 0,1 down; loop 2 up and down together
    wr(`COC_A_STEP_CMD, 32'h0000_0005);
    rchk(`COC_A_LOOP_FREQ, base + 32'h10);
    wr(`COC_A_STEP_CMD, 32'h0000_000e);
    wr(`COC_A_STEP_CMD, 32'h0000_0013);
    rchk(`COC_A_LOOP_FREQ, base);
    rchk(8'h09, base - 32'h10);
    rchk(8'h0a, base);
    $display("test step command done");
    wr(`COC_A_STEP_PIN, 32'h0000_0002);
    @(posedge clk_sys);
    step_up_pin <= 1'b1;
    idle(6);
    step_up_pin <= 1'b0;
    idle(4);
    rchk(8'h09, base);
    rchk(`COC_A_LOOP_FREQ, base);
    @(posedge clk_sys);
    step_down_pin <= 1'b1;
    idle(6);
    step_down_pin <= 1'b0;
    idle(4);
    rchk(8'h09, base - 32'h10);
    $display("test step pins done");
    // driver 1 on both groups, software bit set but ignored
    wr(8'h21, 32'h0000_003c);
    for (k = 0; k < 4; k++) begin
      @(posedge clk_sys);
      enable_group_zero <= k[0];
      enable_group_one <= k[1];
      idle(12);
      rchk(`COC_A_OUT_EN, (k == 0) ? 32'h0003_fffd : 32'h0003_ffff);
      rchk(`COC_A_STATUS, k << 1);
    end
    wr(8'h22, 32'h0000_0000);
    idle(12);
    rchk(`COC_A_OUT_EN, 32'h0003_fffb);
    $display("test enables done");
    for (k = 0; k < 8; k++) begin
      wr(8'h23, cfg_t[k]);
      idle(12);
      @(negedge clk_sys);
      chk({27'h0, oe_p[3], out_p[3], out_n[3], weak_up[3], weak_dn[3]},
          {27'h0, exp_t[k]});
      chk({31'h0, oe_n[3]}, {31'h0, exp_t[k][4]});
    end
    $display("test idle states done");
    wr(`COC_A_CTRL, 32'h0000_0002);
    wr(8'h44, 32'h0006_0004);
    wr(`COC_A_EXT_FB, 32'h0000_0005);
    wr(8'h30, 32'h0000_8020);
    wr(`COC_A_FRAC_SRC, 32'h0000_0003);
    idle(2);
    @(negedge clk_sys);
    chk({30'h0, fine_phase[9:8]}, 32'h0000_0002);
    chk({29'h0, external_feedback_delay_mode}, 32'h0000_0005);
    chk({30'h0, slow_edge_cmos}, 32'h0000_0001);
    rchk(`COC_A_FRAC_SRC, 32'h0000_0003);
    $display("test skew and modes done");
    finish_test();
  end
endmodule : tb_clock_output_control

bind coc_clock_output_control coc_clock_output_control_assertions u_chk (
  .clk_sys(clk_sys), .reset_n(reset_n), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .nvm_addr(nvm_addr), .out_p(out_p), .out_n(out_n), .oe_p(oe_p), .oe_n(oe_n),
  .weak_up(weak_up),
  .weak_dn(weak_dn), .load_busy(load_busy));
